//--- inc/gdm_pkg.sv
// constants, types and register map for the gear-down / power-saving block
package gdm_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TIM0 = 8'h08;
  localparam logic [7:0] OFS_TIM1 = 8'h0C;
  localparam logic [7:0] OFS_TIM2 = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  // mode-register numbers and bit positions
  localparam logic [2:0] MR_GEAR = 3'h3;
  localparam logic [2:0] MR_PWR = 3'h4;
  localparam int GD_BIT = 3;
  localparam int MPS_BIT = 1;
  localparam int ABORT_BIT = 9;
  // command codes on the cmd pins, valid while cs_n is low
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_MRS = 3'h1;
  localparam logic [2:0] CMD_SRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h4;
  localparam logic [2:0] CMD_WR = 3'h5;
  localparam logic [2:0] CMD_PRE = 3'h6;
  localparam logic [2:0] CMD_REF = 3'h7;
  // status field positions
  localparam int ST_GEAR2N = 0;
  localparam int ST_MPS = 1;
  localparam int ST_DLLOK = 2;
  localparam int ST_ERR = 3;
  localparam int ST_STATE = 4;
  // timing reset values, in CK cycles
  localparam logic [15:0] RST_XS = 16'h0100;
  localparam logic [15:0] RST_XS_ABORT = 16'h0040;
  localparam logic [7:0] RST_SYNC_GEAR = 8'h08;
  localparam logic [7:0] RST_CMD_GEAR = 8'h08;
  localparam logic [7:0] RST_MPED = 8'h10;
  localparam logic [7:0] RST_CKMPX = 8'h10;
  localparam logic [15:0] RST_XMP = 16'h0100;
  localparam logic [15:0] RST_XMP_DLL = 16'h0300;

  typedef struct packed {
    logic cs_n;
    logic cke;
    logic ck;
    logic [2:0] cmd;
    logic [2:0] mr;
    logic [13:0] addr;
    logic pda_n;
  } gdm_pins_t;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [2:0] mr;
    logic [13:0] addr;
  } gdm_cmd_t;

  typedef enum logic [3:0] {
    GS_RESET, GS_1N, GS_GD_SYNC, GS_GD_WAIT, GS_2N, GS_SREF, GS_SRX,
    GS_MPS_ENT, GS_MPS, GS_MPS_CK, GS_MPS_XMP
  } gdm_state_t;
endpackage

//--- hw/gdm_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module gdm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- hw/gdm_top.sv
// gear-down and maximum power saving mode logic with APB registers
`timescale 1ns/1ps
`default_nettype none
module gdm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gdm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dram_reset_n,
  input wire gdm_pkg::gdm_pins_t pins,
  output gdm_pkg::gdm_cmd_t cmd_out,
  output logic capture,
  output logic gear_2n,
  output logic refresh_en,
  output logic dll_ok
);
  localparam int PW = $bits(gdm_pkg::gdm_pins_t);

  gdm_pkg::gdm_pins_t ps;
  logic rst_s;
  logic ck_prev_q;
  logic cke_prev_q;

  gdm_sync #(.W(PW + 1), .INIT({1'b0, {PW{1'b1}}})) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({dram_reset_n, pins}),
    .q({rst_s, ps})
  );

  // CK and CKE edges seen in the pclk domain; CK may stand still
  logic ck_en;
  logic cke_rise;
  assign ck_en = ps.ck & ~ck_prev_q;
  assign cke_rise = ps.cke & ~cke_prev_q;

  // software-visible timing and configuration
  logic [15:0] xs_q, xs_d, xsa_q, xsa_d, xmp_q, xmp_d, xmpd_q, xmpd_d;
  logic [7:0] sync_gear_q, sync_gear_d, cmd_gear_q, cmd_gear_d;
  logic [7:0] mped_q, mped_d, ckmpx_q, ckmpx_d;
  logic pda_mode_q, pda_mode_d;
  logic [31:0] prdata_q, prdata_d;
  logic err_clr;

  // mode state
  gdm_pkg::gdm_state_t st_q, st_d;
  logic [gdm_pkg::CNT_W-1:0] cnt_q, cnt_d, dcnt_q, dcnt_d, edge_idx;
  logic gd_en_q, gd_en_d, mps_en_q, mps_en_d, abort_q, abort_d;
  logic gear_q, gear_d, phase_q, phase_d, dll_q, dll_d, err_q, err_d;
  logic cap_q, cap_d;
  gdm_pkg::gdm_cmd_t cmd_q, cmd_d;

  logic sel;
  logic on_edge;
  logic is_mrs;
  logic pda_ok;
  assign sel = ~ps.cs_n;
  assign edge_idx = cnt_q + 16'h0001;
  // in 2N only every other CK edge, counted from the sync pulse, samples
  assign on_edge = ck_en & (~gear_q | ~phase_q);
  assign is_mrs = sel & (ps.cmd == gdm_pkg::CMD_MRS);
  assign pda_ok = ~pda_mode_q | ~ps.pda_n;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dcnt_d = dcnt_q;
    gd_en_d = gd_en_q;
    mps_en_d = mps_en_q;
    abort_d = abort_q;
    gear_d = gear_q;
    phase_d = phase_q;
    dll_d = dll_q;
    err_d = err_q & ~err_clr;
    cap_d = on_edge;
    cmd_d = '0;
    if (ck_en) begin
      phase_d = ~phase_q;
    end
    if (ck_en && !dll_q) begin
      dcnt_d = dcnt_q + 16'h0001;
      if (dcnt_d >= xmpd_q) begin
        dll_d = 1'b1;
      end
    end
    unique case (st_q)
      gdm_pkg::GS_RESET: begin
        if (rst_s) begin
          st_d = gdm_pkg::GS_1N;
        end
      end
      gdm_pkg::GS_1N, gdm_pkg::GS_2N: begin
        if (on_edge && sel) begin
          if (!dll_q && (ps.cmd == gdm_pkg::CMD_RD ||
              ps.cmd == gdm_pkg::CMD_WR)) begin
            err_d = 1'b1;
          end else begin
            cmd_d = '{1'b1, ps.cmd, ps.mr, ps.addr};
          end
          if (is_mrs && ps.mr == gdm_pkg::MR_GEAR) begin
            gd_en_d = ps.addr[gdm_pkg::GD_BIT];
            if (ps.addr[gdm_pkg::GD_BIT] && st_q == gdm_pkg::GS_1N) begin
              st_d = gdm_pkg::GS_GD_SYNC;
              cnt_d = '0;
            end
          end
          if (is_mrs && ps.mr == gdm_pkg::MR_PWR) begin
            abort_d = ps.addr[gdm_pkg::ABORT_BIT];
            if (ps.addr[gdm_pkg::MPS_BIT] && pda_ok) begin
              mps_en_d = 1'b1;
              gear_d = 1'b0;
              st_d = gdm_pkg::GS_MPS_ENT;
              cnt_d = '0;
            end
          end
          if (ps.cmd == gdm_pkg::CMD_SRE) begin
            gear_d = 1'b0;
            st_d = gdm_pkg::GS_SREF;
          end
        end
      end
      gdm_pkg::GS_GD_SYNC: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          // sync is a NOP on an even edge, at least sync-gear after MRS
          if (sel && ps.cmd == gdm_pkg::CMD_NOP && !edge_idx[0] &&
              edge_idx >= {8'h00, sync_gear_q}) begin
            st_d = gdm_pkg::GS_GD_WAIT;
            cnt_d = '0;
            phase_d = 1'b1;
          end else if (sel) begin
            err_d = 1'b1;
          end
        end
      end
      gdm_pkg::GS_GD_WAIT: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          if (sel) begin
            err_d = 1'b1;
          end
          if (edge_idx >= {8'h00, cmd_gear_q}) begin
            st_d = gdm_pkg::GS_2N;
            gear_d = 1'b1;
          end
        end
      end
      gdm_pkg::GS_SREF: begin
        if (cke_rise) begin
          st_d = gdm_pkg::GS_SRX;
          cnt_d = '0;
        end
      end
      gdm_pkg::GS_SRX: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          if (sel) begin
            err_d = 1'b1;
          end
          if (edge_idx >= (abort_q ? xsa_q : xs_q)) begin
            st_d = gdm_pkg::GS_1N;
          end
        end
      end
      gdm_pkg::GS_MPS_ENT: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          if (sel) begin
            err_d = 1'b1;
          end
          if (edge_idx >= {8'h00, mped_q}) begin
            st_d = gdm_pkg::GS_MPS;
          end
        end
      end
      gdm_pkg::GS_MPS: begin
        // only CKE rise with CS level counts; CK and commands are ignored
        if (cke_rise && sel) begin
          st_d = gdm_pkg::GS_MPS_CK;
          cnt_d = '0;
        end
      end
      gdm_pkg::GS_MPS_CK: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          if (edge_idx >= {8'h00, ckmpx_q}) begin
            st_d = gdm_pkg::GS_MPS_XMP;
            cnt_d = '0;
            mps_en_d = 1'b0;
            dll_d = 1'b0;
            dcnt_d = '0;
          end
        end
      end
      gdm_pkg::GS_MPS_XMP: begin
        if (ck_en) begin
          cnt_d = edge_idx;
          if (sel) begin
            err_d = 1'b1;
          end
          if (edge_idx >= xmp_q) begin
            st_d = gdm_pkg::GS_1N;
          end
        end
      end
      default: begin
        st_d = gdm_pkg::GS_RESET;
      end
    endcase
    if (!rst_s) begin
      st_d = gdm_pkg::GS_RESET;
      gd_en_d = 1'b0;
      mps_en_d = 1'b0;
      abort_d = 1'b0;
      gear_d = 1'b0;
      dll_d = 1'b1;
      cmd_d = '0;
      cap_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= gdm_pkg::GS_RESET;
      cnt_q <= '0;
      dcnt_q <= '0;
      gd_en_q <= 1'b0;
      mps_en_q <= 1'b0;
      abort_q <= 1'b0;
      gear_q <= 1'b0;
      phase_q <= 1'b0;
      dll_q <= 1'b1;
      err_q <= 1'b0;
      cap_q <= 1'b0;
      cmd_q <= '0;
      // match the synchroniser's idle ones so no false edge follows reset
      ck_prev_q <= 1'b1;
      cke_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dcnt_q <= dcnt_d;
      gd_en_q <= gd_en_d;
      mps_en_q <= mps_en_d;
      abort_q <= abort_d;
      gear_q <= gear_d;
      phase_q <= phase_d;
      dll_q <= dll_d;
      err_q <= err_d;
      cap_q <= cap_d;
      cmd_q <= cmd_d;
      ck_prev_q <= ps.ck;
      cke_prev_q <= ps.cke;
    end
  end

  assign cmd_out = cmd_q;
  assign capture = cap_q;
  assign gear_2n = gear_q;
  assign dll_ok = dll_q;
  // no refresh in power saving; data is not kept there
  assign refresh_en = (st_q != gdm_pkg::GS_MPS_ENT) &&
    (st_q != gdm_pkg::GS_MPS) && (st_q != gdm_pkg::GS_MPS_CK) &&
    (st_q != gdm_pkg::GS_MPS_XMP);

  // APB slave: zero wait states, read data caught in the setup cycle
  function automatic logic mapped(input logic [gdm_pkg::ADDR_W-1:0] a);
    mapped = (a == gdm_pkg::OFS_MODE) || (a == gdm_pkg::OFS_STAT) ||
      (a == gdm_pkg::OFS_TIM0) || (a == gdm_pkg::OFS_TIM1) ||
      (a == gdm_pkg::OFS_TIM2) || (a == gdm_pkg::OFS_CFG);
  endfunction

  logic wr_acc;
  assign wr_acc = psel & penable & pwrite & mapped(paddr);
  assign err_clr = wr_acc && paddr == gdm_pkg::OFS_STAT &&
    pwdata[gdm_pkg::ST_ERR];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = prdata_q;

  always_comb begin
    xs_d = xs_q;
    xsa_d = xsa_q;
    xmp_d = xmp_q;
    xmpd_d = xmpd_q;
    sync_gear_d = sync_gear_q;
    cmd_gear_d = cmd_gear_q;
    mped_d = mped_q;
    ckmpx_d = ckmpx_q;
    pda_mode_d = pda_mode_q;
    prdata_d = prdata_q;
    if (wr_acc) begin
      unique case (paddr)
        gdm_pkg::OFS_TIM0: begin
          xs_d = pwdata[15:0];
          xsa_d = pwdata[31:16];
        end
        gdm_pkg::OFS_TIM1: begin
          ckmpx_d = pwdata[7:0];
          mped_d = pwdata[15:8];
          sync_gear_d = pwdata[23:16];
          cmd_gear_d = pwdata[31:24];
        end
        gdm_pkg::OFS_TIM2: begin
          xmp_d = pwdata[15:0];
          xmpd_d = pwdata[31:16];
        end
        gdm_pkg::OFS_CFG: begin
          pda_mode_d = pwdata[0];
        end
        default: begin
        end
      endcase
    end
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        gdm_pkg::OFS_MODE: begin
          prdata_d[gdm_pkg::GD_BIT] = gd_en_q;
          prdata_d[gdm_pkg::MPS_BIT] = mps_en_q;
          prdata_d[gdm_pkg::ABORT_BIT] = abort_q;
        end
        gdm_pkg::OFS_STAT: begin
          prdata_d[gdm_pkg::ST_GEAR2N] = gear_q;
          prdata_d[gdm_pkg::ST_MPS] = ~refresh_en;
          prdata_d[gdm_pkg::ST_DLLOK] = dll_q;
          prdata_d[gdm_pkg::ST_ERR] = err_q;
          prdata_d[gdm_pkg::ST_STATE +: 4] = st_q;
        end
        gdm_pkg::OFS_TIM0: prdata_d = {xsa_q, xs_q};
        gdm_pkg::OFS_TIM1: begin
          prdata_d = {cmd_gear_q, sync_gear_q, mped_q, ckmpx_q};
        end
        gdm_pkg::OFS_TIM2: prdata_d = {xmpd_q, xmp_q};
        gdm_pkg::OFS_CFG: prdata_d[0] = pda_mode_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs_q <= gdm_pkg::RST_XS;
      xsa_q <= gdm_pkg::RST_XS_ABORT;
      xmp_q <= gdm_pkg::RST_XMP;
      xmpd_q <= gdm_pkg::RST_XMP_DLL;
      sync_gear_q <= gdm_pkg::RST_SYNC_GEAR;
      cmd_gear_q <= gdm_pkg::RST_CMD_GEAR;
      mped_q <= gdm_pkg::RST_MPED;
      ckmpx_q <= gdm_pkg::RST_CKMPX;
      pda_mode_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      xs_q <= xs_d;
      xsa_q <= xsa_d;
      xmp_q <= xmp_d;
      xmpd_q <= xmpd_d;
      sync_gear_q <= sync_gear_d;
      cmd_gear_q <= cmd_gear_d;
      mped_q <= mped_d;
      ckmpx_q <= ckmpx_d;
      pda_mode_q <= pda_mode_d;
      prdata_q <= prdata_d;
    end
  end
endmodule
`default_nettype wire

//--- dv/gdm_top_props.sv
// concurrent checks on the gear-down / power-saving block ports
`timescale 1ns/1ps
`default_nettype none
module gdm_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [gdm_pkg::ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic dram_reset_n,
  input wire gdm_pkg::gdm_cmd_t cmd_out,
  input wire logic capture,
  input wire logic gear_2n,
  input wire logic refresh_en,
  input wire logic dll_ok
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bus_error: assert property (psel && penable &&
    (paddr > gdm_pkg::OFS_CFG || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no slave error on unmapped access");
  a_reset_halfrate: assert property ((!dram_reset_n)[*4] |=> !gear_2n)
    else $error("2N kept through dram reset");
  a_sref_halfrate: assert property (cmd_out.valid &&
    cmd_out.code == gdm_pkg::CMD_SRE |-> ##[0:2] !gear_2n)
    else $error("2N kept in self refresh");
  a_mps_halfrate: assert property (!refresh_en && $past(!refresh_en)
    |-> !gear_2n)
    else $error("2N kept in power saving");
  a_mps_entry: assert property (cmd_out.valid &&
    cmd_out.code == gdm_pkg::CMD_MRS && cmd_out.mr == gdm_pkg::MR_PWR &&
    cmd_out.addr[gdm_pkg::MPS_BIT] |-> ##[0:2] !refresh_en)
    else $error("power saving not entered");
  a_mps_ignore: assert property (!refresh_en &&
    $past(!refresh_en, 2) |-> !cmd_out.valid)
    else $error("command passed in power saving");
  a_cmd_aligned: assert property (cmd_out.valid |-> capture)
    else $error("command off a sampling edge");
  a_2n_spacing: assert property (capture && gear_2n &&
    $past(gear_2n) |=> (!capture)[*7])
    else $error("2N sampling edges too close");
  a_exit_dll: assert property ($fell(dll_ok) |-> !refresh_en)
    else $error("dll loss outside power saving exit");
  a_dll_gate: assert property (!dll_ok && cmd_out.valid |->
    cmd_out.code != gdm_pkg::CMD_RD && cmd_out.code != gdm_pkg::CMD_WR)
    else $error("data command passed without dll");
endmodule
bind gdm_top gdm_top_props u_gdm_top_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .dram_reset_n(dram_reset_n), .cmd_out(cmd_out),
  .capture(capture), .gear_2n(gear_2n), .refresh_en(refresh_en),
  .dll_ok(dll_ok));
`default_nettype wire

//--- dv/gdm_ctl_model.sv
// memory controller model driving the dram pins
`timescale 1ns/1ps
`default_nettype none
module gdm_ctl_model (
  input wire logic pclk,
  output gdm_pkg::gdm_pins_t pins,
  output logic dram_reset_n
);
  initial begin
    pins = '1;
    pins.cke = 1'h0;
    dram_reset_n = 1'h0;
  end
  // each ck level stands two pclk so the synchroniser sees it
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge pclk);
      pins.ck <= 1'h0;
      @(posedge pclk);
      @(posedge pclk);
      pins.ck <= 1'h1;
      @(posedge pclk);
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [2:0] m,
    input logic [13:0] a, input int n);
    @(posedge pclk);
    pins.cs_n <= 1'h0;
    {pins.cmd, pins.mr, pins.addr} <= {c, m, a};
    edges(n);
    @(posedge pclk);
    pins.cs_n <= 1'h1;
    // released lines never keep the last value
    {pins.cmd, pins.mr, pins.addr} <= ~{c, m, a};
  endtask
  task automatic lines(input logic ke, input logic cs);
    @(posedge pclk);
    pins.cke <= ke;
    pins.cs_n <= cs;
    repeat (3) @(posedge pclk);
  endtask
  task automatic power_up;
    repeat (4) @(posedge pclk);
    dram_reset_n <= 1'h1;
    repeat (4) @(posedge pclk);
    pins.cke <= 1'h1;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- dv/gdm_top_test.sv
// self-checking bench for the gear-down / power-saving block
`timescale 1ns/1ps
`default_nettype none
module gdm_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic dram_reset_n, capture, gear_2n, refresh_en, dll_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gdm_pkg::gdm_pins_t pins;
  gdm_pkg::gdm_cmd_t cmd_out;
  int fails, total_checks, caps, cmds;
  gdm_pkg::gdm_cmd_t last_cmd;
  gdm_top u_gdm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dram_reset_n(dram_reset_n), .pins(pins), .cmd_out(cmd_out),
    .capture(capture), .gear_2n(gear_2n), .refresh_en(refresh_en),
    .dll_ok(dll_ok));
  gdm_ctl_model u_gdm_ctl_model (.pclk(pclk), .pins(pins),
    .dram_reset_n(dram_reset_n));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (capture === 1'h1) caps <= caps + 1;
    if (cmd_out.valid === 1'h1) begin
      cmds <= cmds + 1;
      last_cmd <= cmd_out;
    end
  end
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 16) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic c(input logic [2:0] k, input logic [2:0] m,
    input logic [13:0] a, input int n);
    u_gdm_ctl_model.cmd(k, m, a, n);
  endtask
  task automatic e(input int n);
    u_gdm_ctl_model.edges(n);
  endtask
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  task automatic count(input int n, input int x);
    settle();
    caps = 0;
    e(n);
    settle();
    check(32'(caps), 32'(x));
  endtask
  task automatic t_regs;
    apb(1'h0, gdm_pkg::OFS_TIM0, 32'h0000_0000);
    check(rd, {gdm_pkg::RST_XS_ABORT, gdm_pkg::RST_XS});
    apb(1'h0, gdm_pkg::OFS_TIM1, 32'h0000_0000);
    check(rd, {gdm_pkg::RST_CMD_GEAR, gdm_pkg::RST_SYNC_GEAR,
      gdm_pkg::RST_MPED, gdm_pkg::RST_CKMPX});
    apb(1'h0, gdm_pkg::OFS_TIM2, 32'h0000_0000);
    check(rd, {gdm_pkg::RST_XMP_DLL, gdm_pkg::RST_XMP});
    apb(1'h0, gdm_pkg::OFS_MODE, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'h1, 8'h18, 32'hFFFF_FFFF);
    check(er, 1'h1);
    apb(1'h0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(er, 1'h1);
    // short delays keep the run brief
    apb(1'h1, gdm_pkg::OFS_TIM0, 32'h0004_000C);
    apb(1'h1, gdm_pkg::OFS_TIM1, 32'h0404_0404);
    apb(1'h1, gdm_pkg::OFS_TIM2, 32'h000C_0004);
    apb(1'h0, gdm_pkg::OFS_TIM1, 32'h0000_0000);
    check(rd, 32'h0404_0404);
  endtask
  task automatic t_gear;
    check(gear_2n, 1'h0);
    count(4, 4);
    c(gdm_pkg::CMD_MRS, gdm_pkg::MR_GEAR, 14'h0008, 1);
    e(3);
    c(gdm_pkg::CMD_NOP, 3'h0, 14'h0000, 1);
    e(2);
    settle();
    check(gear_2n, 1'h0);
    e(4);
    settle();
    check(gear_2n, 1'h1);
    count(8, 4);
    cmds = 0;
    c(gdm_pkg::CMD_ACT, 3'h0, 14'h0000, 2);
    settle();
    check(32'(cmds), 32'h0000_0001);
    check(32'(last_cmd),
      32'({1'b1, gdm_pkg::CMD_ACT, 3'h0, 14'h0000}));
    // even latency fields and zero additive latency while in 2N
    c(gdm_pkg::CMD_MRS, 3'h0, 14'h0010, 2);
    c(gdm_pkg::CMD_MRS, 3'h1, 14'h0000, 2);
    settle();
    check(32'(last_cmd),
      32'({1'b1, gdm_pkg::CMD_MRS, 3'h1, 14'h0000}));
    apb(1'h0, gdm_pkg::OFS_MODE, 32'h0000_0000);
    check(rd[gdm_pkg::GD_BIT], 1'h1);
  endtask
  task automatic t_sref;
    for (int ab = 0; ab < 2; ab++) begin
      if (ab == 1) c(gdm_pkg::CMD_MRS, gdm_pkg::MR_PWR, 14'h0200, 1);
      c(gdm_pkg::CMD_SRE, 3'h0, 14'h0000, 2 - ab);
      u_gdm_ctl_model.lines(1'h0, 1'h1);
      check(gear_2n, 1'h0);
      u_gdm_ctl_model.lines(1'h1, 1'h1);
      e(6);
      apb(1'h0, gdm_pkg::OFS_STAT, 32'h0000_0000);
      check(rd[7:4], ab ? gdm_pkg::GS_1N : gdm_pkg::GS_SRX);
      e(8);
      apb(1'h0, gdm_pkg::OFS_STAT, 32'h0000_0000);
      check(rd[7:4], gdm_pkg::GS_1N);
      check(gear_2n, 1'h0);
      cmds = 0;
      c(gdm_pkg::CMD_ACT, 3'h0, 14'h0000, 1);
      settle();
      check(32'(cmds), 32'h0000_0001);
    end
  endtask
  task automatic t_mps;
    c(gdm_pkg::CMD_MRS, gdm_pkg::MR_GEAR, 14'h0000, 1);
    c(gdm_pkg::CMD_MRS, gdm_pkg::MR_PWR, 14'h0002, 1);
    settle();
    check(refresh_en, 1'h0);
    e(6);
    cmds = 0;
    c(gdm_pkg::CMD_REF, 3'h0, 14'h0000, 1);
    settle();
    check(32'(cmds), 32'h0000_0000);
    u_gdm_ctl_model.lines(1'h0, 1'h1);
    u_gdm_ctl_model.lines(1'h1, 1'h1);
    apb(1'h0, gdm_pkg::OFS_STAT, 32'h0000_0000);
    check(rd[gdm_pkg::ST_MPS], 1'h1);
    u_gdm_ctl_model.lines(1'h0, 1'h0);
    u_gdm_ctl_model.lines(1'h1, 1'h0);
    u_gdm_ctl_model.lines(1'h1, 1'h1);
    e(6);
    apb(1'h0, gdm_pkg::OFS_MODE, 32'h0000_0000);
    check(rd[gdm_pkg::MPS_BIT], 1'h0);
    check(rd[gdm_pkg::GD_BIT], 1'h0);
    check(dll_ok, 1'h0);
    e(6);
    check(refresh_en, 1'h1);
    c(gdm_pkg::CMD_RD, 3'h0, 14'h0000, 1);
    c(gdm_pkg::CMD_WR, 3'h0, 14'h0000, 1);
    settle();
    check(32'(cmds), 32'h0000_0000);
    apb(1'h0, gdm_pkg::OFS_STAT, 32'h0000_0000);
    check(rd[gdm_pkg::ST_ERR], 1'h1);
    apb(1'h1, gdm_pkg::OFS_STAT, 32'h0000_0001 << gdm_pkg::ST_ERR);
    apb(1'h0, gdm_pkg::OFS_STAT, 32'h0000_0000);
    check(rd[gdm_pkg::ST_ERR], 1'h0);
    e(8);
    check(dll_ok, 1'h1);
    c(gdm_pkg::CMD_RD, 3'h0, 14'h0000, 1);
    settle();
    check(32'(cmds), 32'h0000_0001);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fails, total_checks, caps, cmds} = '0;
    presetn = 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    u_gdm_ctl_model.power_up();
    t_regs();
    t_gear();
    t_sref();
    t_mps();
    stop_test();
  end
endmodule
`default_nettype wire
